// File: core/qpic_bit_capture.sv
/*
  Link-side bit sampler clocked by the serial bus clock.
  Each rising bus clock captures the data line and flips a toggle;
  the system side synchronises both and sees one event per bit.
  Assumes the bus clock stands still between frames.
*/
`timescale 1ns/1ps
module qpic_bit_capture (
  // link clock and reset
  input  wire logic i_scl,
  input  wire logic i_rst_b,
  // data line
  input  wire logic i_sda,
  // captured bit and event toggle
  output logic      o_bit,
  output logic      o_tog
);

  typedef struct packed {
    logic bit_v;
    logic tog;
  } qpic_cap_s;

  qpic_cap_s r;
  qpic_cap_s n;

  always_comb begin
    n       = r;
    n.bit_v = i_sda;
    n.tog   = ~r.tog;
  end

  always_ff @(posedge i_scl or negedge i_rst_b) begin
    if (!i_rst_b) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign o_bit = r.bit_v;
  assign o_tog = r.tog;

endmodule // qpic_bit_capture

// File: core/qpic_pkg.sv
/*
  Shared constants and types of the quad wiper command decoder:
  state codes, instruction opcodes, reset values, write timing.
  Assumes only a SystemVerilog compiler; nothing is imported.
*/
package qpic_pkg;

  // serial engine states, one-hot
  typedef enum logic [6:0] {
    QPIC_IDLE  = 7'h01,
    QPIC_RX    = 7'h02,
    QPIC_ACK   = 7'h04,
    QPIC_TX    = 7'h08,
    QPIC_TXACK = 7'h10,
    QPIC_STEP  = 7'h20,
    QPIC_SKIP  = 7'h40
  } qpic_state_e;

  // instruction opcodes, upper nibble of the instruction byte
  localparam logic [3:0] OP_RD_WIPER  = 4'h9;
  localparam logic [3:0] OP_WR_WIPER  = 4'hA;
  localparam logic [3:0] OP_RD_STORED = 4'hB;
  localparam logic [3:0] OP_WR_STORED = 4'hC;
  localparam logic [3:0] OP_LOAD      = 4'hD;
  localparam logic [3:0] OP_SAVE      = 4'hE;
  localparam logic [3:0] OP_GANG_LOAD = 4'h1;
  localparam logic [3:0] OP_GANG_SAVE = 4'h8;
  localparam logic [3:0] OP_STEP      = 4'h2;

  // byte framing
  localparam logic [2:0] LAST_BIT     = 3'h7;
  localparam logic [1:0] PH_ADDR      = 2'h0;
  localparam logic [1:0] PH_INSTR     = 2'h1;

  // reset values and wiper limits
  localparam logic [7:0] STORED_RST   = 8'h80;
  localparam logic [7:0] WIPER_RST    = 8'h00;
  localparam logic [7:0] WIPER_MAX    = 8'hFF;
  localparam logic [7:0] WIPER_MIN    = 8'h00;

  // non-volatile write time
  localparam int unsigned NONVOLATILE_WRITE_TIME_MS = 10;
  localparam longint unsigned CLK_FREQ_HZ = 64'd250000000;
  localparam int unsigned NONVOLATILE_WRITE_CYCLES =
    int'((64'(NONVOLATILE_WRITE_TIME_MS) * CLK_FREQ_HZ) / 64'd1000);
  localparam int unsigned NV_TMR_W = 22;

endpackage

// File: core/qpic_sync.sv
/*
  Two-flop synchroniser for a bundle of independent levels.
  Assumes each bit is a level held far longer than two clocks.
*/
`timescale 1ns/1ps
module qpic_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst_b,
  // levels
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } qpic_sync_s;

  qpic_sync_s r;
  qpic_sync_s n;

  always_comb begin
    n    = r;
    n.s1 = i_d;
    n.s2 = r.s1;
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign o_q = r.s2;

endmodule // qpic_sync

// File: core/qpic_top.sv
/*
  Command decoder of a quad 256-position digital potentiometer on
  a two-wire serial bus: wiper and stored-setting registers, read,
  write, single and gang copies, and step mode.
  Assumes an external bus master; the data line is open drain and
  the bench resolves it from o_sda and o_sda_oe_b.
*/
//
// Overview of operation
// - address byte: type code plus select pins
// - read wiper returns byte, msb first
// - write wiper loads acknowledged data byte
// - read stored setting returns byte, msb first
// - write stored setting from data byte
// - gang load copies stored to all wipers
// - gang save stores all wipers
// - single save stores selected wiper
// - single load copies stored to wiper
// - step mode: direction bits until stop
// - stepping begins only after instruction acknowledge
// - data high pulse steps toward high terminal
// - data low pulse steps toward low terminal
// - non-volatile write starts only after stop
// - stored change settles within write time
// - power-up loads wipers from first stored setting
`timescale 1ns/1ps
module qpic_top #(
  // device type code; value is arbitrary
  parameter logic [3:0]  DEV_TYPE    = 4'h6,
  parameter int unsigned NVW_CYCLES  =
    qpic_pkg::NONVOLATILE_WRITE_CYCLES
) (
  // system clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  // serial bus
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  output logic             o_sda,
  output logic             o_sda_oe_b,
  // straps
  input  wire logic [3:0]  i_device_select_pins,
  // wiper positions, pot 0 in low byte
  output logic [31:0]      o_wiper_position,
  // non-volatile write in progress
  output logic             o_nv_busy
);

  localparam int CW = qpic_pkg::NV_TMR_W;

  typedef struct packed {
    qpic_pkg::qpic_state_e st;
    logic [1:0]            phase;
    logic [2:0]            cnt;
    logic [7:0]            sh;
    logic                  sda_oe_b;
    logic                  sda_o;
    logic                  ack_clk;
    logic                  scl_d;
    logic                  sda_d;
    logic                  tog_d;
    logic                  tog_d2;
    logic [3:0]            op;
    logic [1:0]            rsel;
    logic [1:0]            psel;
    logic                  step_pend;
    logic                  step_up;
    logic [3:0][7:0]       wiper;
    logic [3:0][3:0][7:0]  stored;
    logic [3:0]            fr_mask;
    logic [3:0][7:0]       fr_val;
    logic [1:0]            fr_reg;
    logic [3:0]            nv_mask;
    logic [3:0][7:0]       nv_val;
    logic [1:0]            nv_reg;
    logic [CW-1:0]         nv_tmr;
    logic                  nv_busy;
    logic                  boot;
  } qpic_top_s;

  qpic_top_s   r;
  qpic_top_s   n;
  logic [7:0]  sync_q;
  logic        cap_bit;
  logic        cap_tog;
  logic        scl_s;
  logic        sda_s;
  logic        tog_s;
  logic        bit_s;
  logic [3:0]  sel_s;
  logic        bit_ev;
  logic        scl_fall;
  logic        start_ev;
  logic        stop_ev;
  logic [7:0]  byte_in;
  logic [7:0]  tx_byte;

  qpic_bit_capture u_cap (
    .i_scl   (i_scl),
    .i_rst_b (i_rst_b),
    .i_sda   (i_sda),
    .o_bit   (cap_bit),
    .o_tog   (cap_tog)
  );

  qpic_sync #(.W(8)) u_sync (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_d     ({cap_bit, cap_tog, i_device_select_pins, i_sda, i_scl}),
    .o_q     (sync_q)
  );

  assign scl_s = sync_q[0];
  assign sda_s = sync_q[1];
  assign sel_s = sync_q[5:2];
  assign tog_s = sync_q[6];
  assign bit_s = sync_q[7];

  // bit event one cycle late so the synced bit is surely settled
  assign bit_ev   = r.tog_d ^ r.tog_d2;
  assign scl_fall = r.scl_d & ~scl_s;
  assign start_ev = r.scl_d & scl_s & r.sda_d & ~sda_s;
  assign stop_ev  = r.scl_d & scl_s & ~r.sda_d & sda_s;

  always_comb begin
    n       = r;
    byte_in = {r.sh[6:0], bit_s};
    tx_byte = r.wiper[r.psel];
    n.scl_d  = scl_s;
    n.sda_d  = sda_s;
    n.tog_d  = tog_s;
    n.tog_d2 = r.tog_d;

    if (r.boot) begin
      for (int p = 0; p < 4; p++) begin
        n.wiper[p] = r.stored[p][0];
      end
      n.boot = 1'b0;
    end

    // delayed commit of a non-volatile write
    if (r.nv_busy) begin
      if (r.nv_tmr == CW'(NVW_CYCLES - 1)) begin
        for (int p = 0; p < 4; p++) begin
          if (r.nv_mask[p]) begin
            n.stored[p][r.nv_reg] = r.nv_val[p];
          end
        end
        n.nv_busy = 1'b0;
      end else begin
        n.nv_tmr = r.nv_tmr + 1'b1;
      end
    end

    case (r.st)
      qpic_pkg::QPIC_RX: begin
        if (bit_ev) begin
          n.sh  = byte_in;
          n.cnt = r.cnt + 1'b1;
          if (r.cnt == qpic_pkg::LAST_BIT) begin
            n.st      = qpic_pkg::QPIC_ACK;
            n.ack_clk = 1'b0;
            case (r.phase)
              qpic_pkg::PH_ADDR: begin
                if (byte_in[7:4] != DEV_TYPE ||
                    byte_in[3:0] != sel_s || r.nv_busy) begin
                  n.st = qpic_pkg::QPIC_SKIP;
                end
              end
              qpic_pkg::PH_INSTR: begin
                n.op   = byte_in[7:4];
                n.rsel = byte_in[3:2];
                n.psel = byte_in[1:0];
                case (byte_in[7:4])
                  qpic_pkg::OP_GANG_LOAD: begin
                    for (int p = 0; p < 4; p++) begin
                      n.wiper[p] = r.stored[p][byte_in[3:2]];
                    end
                  end
                  qpic_pkg::OP_GANG_SAVE: begin
                    n.fr_mask = 4'hF;
                    n.fr_val  = r.wiper;
                    n.fr_reg  = byte_in[3:2];
                  end
                  qpic_pkg::OP_SAVE: begin
                    n.fr_mask = 4'(4'h1 << byte_in[1:0]);
                    n.fr_val[byte_in[1:0]] = r.wiper[byte_in[1:0]];
                    n.fr_reg  = byte_in[3:2];
                  end
                  qpic_pkg::OP_LOAD: begin
                    n.wiper[byte_in[1:0]] =
                      r.stored[byte_in[1:0]][byte_in[3:2]];
                  end
                  default: begin
                    // reads, writes, step: act later; others
                  end
                endcase
              end
              default: begin
                if (r.op == qpic_pkg::OP_WR_WIPER) begin
                  n.wiper[r.psel] = byte_in;
                end else begin
                  n.fr_mask = 4'(4'h1 << r.psel);
                  n.fr_val[r.psel] = byte_in;
                  n.fr_reg  = r.rsel;
                end
              end
            endcase
          end
        end
      end

      qpic_pkg::QPIC_ACK: begin
        if (bit_ev) begin
          n.ack_clk = 1'b1;
        end
        if (scl_fall) begin
          if (!r.ack_clk) begin
            n.sda_oe_b = 1'b0;
          end else begin
            n.sda_oe_b = 1'b1;
            n.cnt      = '0;
            n.ack_clk  = 1'b0;
            case (r.phase)
              qpic_pkg::PH_ADDR: begin
                n.st    = qpic_pkg::QPIC_RX;
                n.phase = qpic_pkg::PH_INSTR;
              end
              qpic_pkg::PH_INSTR: begin
                case (r.op)
                  qpic_pkg::OP_RD_WIPER, qpic_pkg::OP_RD_STORED: begin
                    if (r.op == qpic_pkg::OP_RD_STORED) begin
                      tx_byte = r.stored[r.psel][r.rsel];
                    end
                    n.st       = qpic_pkg::QPIC_TX;
                    n.sh       = tx_byte;
                    n.sda_oe_b = tx_byte[7];
                  end
                  qpic_pkg::OP_WR_WIPER, qpic_pkg::OP_WR_STORED: begin
                    n.st    = qpic_pkg::QPIC_RX;
                    n.phase = 2'h2;
                  end
                  qpic_pkg::OP_STEP: begin
                    n.st = qpic_pkg::QPIC_STEP;
                  end
                  default: begin
                    n.st = qpic_pkg::QPIC_SKIP;
                  end
                endcase
              end
              default: begin
                n.st = qpic_pkg::QPIC_SKIP;
              end
            endcase
          end
        end
      end

      qpic_pkg::QPIC_TX: begin
        if (bit_ev) begin
          n.cnt = r.cnt + 1'b1;
          n.sh  = {r.sh[6:0], 1'b0};
          if (r.cnt == qpic_pkg::LAST_BIT) begin
            n.st = qpic_pkg::QPIC_TXACK;
          end
        end
        if (scl_fall) begin
          n.sda_oe_b = r.sh[7];
        end
      end

      qpic_pkg::QPIC_TXACK: begin
        if (scl_fall) begin
          n.sda_oe_b = 1'b1;
        end
        if (bit_ev) begin
          n.st = qpic_pkg::QPIC_SKIP;
        end
      end

      qpic_pkg::QPIC_STEP: begin
        // step applied at the falling clock, so a stop's rise is inert
        if (bit_ev) begin
          n.step_pend = 1'b1;
          n.step_up   = bit_s;
        end
        if (scl_fall && r.step_pend) begin
          n.step_pend = 1'b0;
          if (r.step_up) begin
            if (r.wiper[r.psel] != qpic_pkg::WIPER_MAX) begin
              n.wiper[r.psel] = r.wiper[r.psel] + 1'b1;
            end
          end else begin
            if (r.wiper[r.psel] != qpic_pkg::WIPER_MIN) begin
              n.wiper[r.psel] = r.wiper[r.psel] - 1'b1;
            end
          end
        end
      end

      qpic_pkg::QPIC_IDLE, qpic_pkg::QPIC_SKIP: begin
      end

      default: begin
        n.st = qpic_pkg::QPIC_IDLE;
      end
    endcase

    if (start_ev) begin
      n.st        = qpic_pkg::QPIC_RX;
      n.phase     = qpic_pkg::PH_ADDR;
      n.cnt       = '0;
      n.sda_oe_b  = 1'b1;
      n.ack_clk   = 1'b0;
      n.step_pend = 1'b0;
      n.fr_mask   = '0;
    end

    if (stop_ev) begin
      n.st        = qpic_pkg::QPIC_IDLE;
      n.sda_oe_b  = 1'b1;
      n.step_pend = 1'b0;
      n.fr_mask   = '0;
      if (r.fr_mask != 4'h0 && !r.nv_busy) begin
        n.nv_mask = r.fr_mask;
        n.nv_val  = r.fr_val;
        n.nv_reg  = r.fr_reg;
        n.nv_tmr  = '0;
        n.nv_busy = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      r          <= '0;
      r.st       <= qpic_pkg::QPIC_IDLE;
      r.sda_oe_b <= 1'b1;
      r.scl_d    <= 1'b1;
      r.sda_d    <= 1'b1;
      r.wiper    <= {4{qpic_pkg::WIPER_RST}};
      r.stored   <= {16{qpic_pkg::STORED_RST}};
      r.boot     <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign o_sda            = r.sda_o;
  assign o_sda_oe_b       = r.sda_oe_b;
  assign o_wiper_position = r.wiper;
  assign o_nv_busy        = r.nv_busy;

endmodule // qpic_top

// File: verification/qpic_bus_master.sv
/* Serial bus master model for the wiper command decoder.
   Assumes the bench resolves the data line with a pull-up. */
`timescale 1ns/1ps
module qpic_bus_master #(
  parameter int HALF = 18
) (
  // tick clock and data line
  input  wire logic i_lclk,
  input  wire logic i_sda,
  // bus drive
  output logic      o_scl,
  output logic      o_sda_low
);
  initial o_scl = 1'b1;
  initial o_sda_low = 1'b0;
  task automatic tick(input int n);
    repeat (n) @(posedge i_lclk);
  endtask
  // clock idles high; start and stop move data while it is high
  task automatic start();
    tick(HALF);
    o_sda_low <= 1'b1;
    tick(HALF);
    o_scl <= 1'b0;
  endtask
  task automatic stop();
    tick(HALF);
    o_sda_low <= 1'b1;
    tick(HALF);
    o_scl <= 1'b1;
    tick(HALF);
    o_sda_low <= 1'b0;
    tick(HALF);
  endtask
  task automatic xbit(input logic b, output logic r);
    tick(HALF / 2);
    o_sda_low <= ~b;
    tick(HALF / 2);
    o_scl <= 1'b1;
    tick(HALF);
    r = i_sda;
    o_scl <= 1'b0;
  endtask
  // msb first, then the ninth slot left released
  task automatic xbyte(input logic [7:0] d, output logic [7:0] r,
                       output logic a);
    for (int i = 7; i >= 0; i--) xbit(d[i], r[i]);
    xbit(1'b1, a);
  endtask
endmodule // qpic_bus_master

// File: verification/qpic_sva.sv
/* Port checker of qpic_top.
   Assumes it is bound to qpic_top; bus lines sampled on i_clk. */
`timescale 1ns/1ps
module qpic_sva #(
  parameter int unsigned NVW_CYCLES = 50
) (
  // watched ports
  input wire logic        i_clk,
  input wire logic        i_rst_b,
  input wire logic        i_scl,
  input wire logic        i_sda,
  input wire logic        o_sda,
  input wire logic        o_sda_oe_b,
  input wire logic [31:0] o_wiper_position,
  input wire logic        o_nv_busy
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  int unsigned quiet_r;
  int unsigned busy_r;
  int unsigned stop_r;
  logic [1:0]  bus_r;
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      bus_r   <= 2'h3;
      quiet_r <= 0;
      busy_r  <= 0;
      stop_r  <= 99;
    end else begin
      bus_r   <= {i_scl, i_sda};
      quiet_r <= ({i_scl, i_sda} != bus_r) ? 0 : quiet_r + 1;
      busy_r  <= o_nv_busy ? busy_r + 1 : 0;
      stop_r  <= (bus_r == 2'h2 && i_scl && i_sda) ? 0 : stop_r + 1;
    end
  end
  sequence nv_run;
    o_nv_busy [*8];
  endsequence
  chk_drive_zero: assert property (o_sda == 1'b0)
    else $error("data drive not zero");
  chk_power_load: assert property ($rose(i_rst_b) |-> ##[0:2]
    o_wiper_position == 32'h80808080) else $error("wipers not loaded");
  chk_write_span: assert property ($fell(o_nv_busy) |->
    busy_r >= NVW_CYCLES - 2 && busy_r <= NVW_CYCLES + 2)
    else $error("write time wrong");
  chk_write_after_stop: assert property ($rose(o_nv_busy) |->
    (stop_r <= 8) ##0 nv_run) else $error("write not after stop");
  chk_busy_nack: assert property (
    o_nv_busy && $past(o_nv_busy, 8) |-> o_sda_oe_b)
    else $error("busy device pulls data");
  chk_busy_hold: assert property (
    o_nv_busy && $past(o_nv_busy) |-> $stable(o_wiper_position))
    else $error("wiper moved while busy");
  chk_quiet_wiper: assert property (
    quiet_r > 12 |-> $stable(o_wiper_position))
    else $error("wiper moved on idle bus");
  chk_pull_low: assert property ($fell(o_sda_oe_b) |->
    !i_scl && !$past(i_scl, 2)) else $error("pull while clock high");
endmodule // qpic_sva

bind qpic_top qpic_sva #(.NVW_CYCLES(NVW_CYCLES)) u_sva (.i_clk,
  .i_rst_b, .i_scl, .i_sda, .o_sda, .o_sda_oe_b, .o_wiper_position,
  .o_nv_busy);

// File: verification/qpic_top_tb.sv
/* Bench of qpic_top: master model, expected register images.
   Assumes qpic_pkg, qpic_top, the master model and the checker. */
`timescale 1ns/1ps
module qpic_top_tb;
  localparam int unsigned NVW = 1000;
  localparam logic [3:0] DEV = 4'h9; // type code, value arbitrary
  localparam logic [7:0] STEPS [3][3] = '{'{8'hFD, 8'h85, 8'hFF},
    '{8'h02, 8'h04, 8'h00}, '{8'h40, 8'h03, 8'h3D}};
  typedef struct {
    string      nm;
    logic [7:0] v;
  } qpic_note_s;
  logic        i_clk = 1'b0;
  logic        i_rst_b = 1'b0;
  logic        lclk = 1'b0;
  logic [3:0]  sel = 4'h0;
  logic        scl;
  logic        sda_low;
  logic        sda_d;
  logic        oe_b;
  logic        busy;
  logic [31:0] wpos;
  wire logic   sda = (oe_b | sda_d) & ~sda_low;
  logic [7:0]  wm [4];
  logic [7:0]  sm [4][4];
  qpic_note_s  notes [$];
  logic [7:0]  res_v;
  event        res_ev;
  int          err_total = 0;
  int          comparisons = 0;
  int          cyc = 0;
  always #2 i_clk = ~i_clk;
  initial #1.3 forever #3 lclk = ~lclk;
  qpic_top #(.DEV_TYPE(DEV), .NVW_CYCLES(NVW)) u_dut (.i_clk,
    .i_rst_b, .i_scl(scl), .i_sda(sda), .o_sda(sda_d),
    .o_sda_oe_b(oe_b), .i_device_select_pins(sel),
    .o_wiper_position(wpos), .o_nv_busy(busy));
  qpic_bus_master u_mst (.i_lclk(lclk), .i_sda(sda), .o_scl(scl),
    .o_sda_low(sda_low));
  task automatic results();
    $display("comparisons %0d errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    notes.push_back('{nm, e});
    res_v = g;
    ->res_ev;
    #1;
  endtask
  task automatic chkw();
    for (int p = 0; p < 4; p++) chk("wiper", wm[p], wpos[8*p+:8]);
  endtask
  task automatic nvwait();
    for (int n = 0; n < 20 && !busy; n++) @(posedge i_clk);
    for (int n = 0; n < NVW + 20 && busy; n++) @(posedge i_clk);
    chk("busy", 8'h0, {7'h0, busy});
  endtask
  // kind 0 two bytes, 1 data byte, 2 read byte, 3 step pulses
  task automatic frame(input logic [3:0] a, input logic [7:0] ins,
    input int kind, input logic [7:0] d, input logic ok,
    output logic [7:0] r);
    logic [2:0] ak;
    logic [7:0] x;
    ak[2] = 1'b1;
    u_mst.start();
    u_mst.xbyte({DEV, a}, x, ak[0]);
    u_mst.xbyte(ins, x, ak[1]);
    if (kind == 1) u_mst.xbyte(d, x, ak[2]);
    if (kind == 2) u_mst.xbyte(8'hFF, r, ak[2]);
    if (kind == 3) repeat (d[6:0]) u_mst.xbit(d[7], x[0]);
    if (ok) chk("busy", 8'h0, {7'h0, busy});
    u_mst.stop();
    chk("acks", {5'h0, ok ? {kind != 1, 2'h0} : 3'h7}, {5'h0, ak});
  endtask
  initial begin : mon
    qpic_note_s n;
    forever begin
      @(res_ev);
      n = notes.pop_front();
      comparisons++;
      if (n.v !== res_v) begin
        err_total++;
        $display("wrong value %s expected %h seen %h", n.nm, n.v, res_v);
      end
    end
  end
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 100000) begin
      err_total++;
      results();
    end
  end
  initial begin : main
    logic [7:0] r;
    logic [7:0] v;
    foreach (sm[p, q]) sm[p][q] = 8'h80;
    foreach (wm[p]) wm[p] = 8'h80;
    @(posedge i_clk);
    sel <= 4'($urandom(32'h1939));
    repeat (20) @(posedge i_clk);
    i_rst_b <= 1'b1;
    repeat (8) @(posedge i_clk);
    chkw();
    for (int p = 0; p < 4; p++) begin
      v = 8'($urandom());
      wm[p] = v;
      frame(sel, {qpic_pkg::OP_WR_WIPER, 2'h0, 2'(p)}, 1, v, 1'b1, r);
      frame(sel, {qpic_pkg::OP_RD_WIPER, 2'h0, 2'(p)}, 2, v, 1'b1, r);
      chk("wiper read", v, r);
    end
    for (int q = 0; q < 4; q++) begin
      v = 8'($urandom());
      sm[1][q] = v;
      frame(sel, {qpic_pkg::OP_WR_STORED, 2'(q), 2'h1}, 1, v, 1'b1, r);
      if (q == 0) frame(sel, 8'hA0, 1, v, 1'b0, r);
      nvwait();
      frame(sel, {qpic_pkg::OP_RD_STORED, 2'(q), 2'h1}, 2, v, 1'b1, r);
      chk("stored read", v, r);
    end
    frame(sel, {qpic_pkg::OP_LOAD, 4'h9}, 0, v, 1'b1, r);
    wm[1] = sm[1][2];
    chkw();
    frame(sel, {qpic_pkg::OP_SAVE, 4'hC}, 0, v, 1'b1, r);
    nvwait();
    frame(sel, {qpic_pkg::OP_RD_STORED, 4'hC}, 2, v, 1'b1, r);
    chk("stored read", wm[0], r);
    frame(sel, {qpic_pkg::OP_GANG_SAVE, 4'h4}, 0, v, 1'b1, r);
    nvwait();
    for (int p = 0; p < 4; p++) sm[p][1] = wm[p];
    frame(sel, {qpic_pkg::OP_WR_WIPER, 4'h2}, 1, ~wm[2], 1'b1, r);
    frame(sel, {qpic_pkg::OP_GANG_LOAD, 4'h4}, 0, v, 1'b1, r);
    chkw();
    for (int k = 0; k < 3; k++) begin
      frame(sel, {qpic_pkg::OP_WR_WIPER, 4'h3}, 1, STEPS[k][0], 1'b1, r);
      frame(sel, {qpic_pkg::OP_STEP, 4'h3}, 3, STEPS[k][1], 1'b1, r);
      wm[3] = STEPS[k][2];
      chkw();
    end
    frame(sel ^ 4'h8, {qpic_pkg::OP_WR_WIPER, 4'h0}, 1, ~wm[0], 1'b0, r);
    for (int k = 0; k < 2; k++) frame(sel, k ? 8'hF2 : 8'h31, 0, v, 1'b1, r);
    chkw();
    results();
  end
endmodule // qpic_top_tb
